// ### scs_device.sv
// Loading device end: request handshake, serial load, initialization
//
// Function
// - User mode: all lines high; host pulls request
// - Host holds request low two microseconds
// - Status and done low within 600 ns
// - Status low pulse 268 to 1506 us
// - Status released within 1506 us after request
// - Host waits after status before first clock
// - Status held low through power-on delay
// - Done low from power-up until load completes
// - Done rises only after all data, error-free
// - Two falling clock edges after done rises
// - Passive mode samples data on rising clock
// - Host parks the clock at fixed level
// - Active mode launches and captures on falling edge
// - Quad active mode takes four bits per clock
// - Active clock from oscillator, four selectable rates
// - No fastest rate when devices are chained
// - Init clock: oscillator or user start clock
// - Oscillator init: user mode 175-437 us after done
// - User clock: delay, then 8576 user edges
// - Init-complete output low once option loaded
// - Serial input pin becomes user I/O afterwards
`timescale 1ns/1ps
module scs_device #(
  parameter int W = 8,
  parameter int DEPTH = 16,
  parameter int CFG_BITS = 64,
  parameter int STATUS_LOW_CYC = scs_pkg::STATUS_LOW_CYC,
  parameter int INIT_CYC = scs_pkg::INIT_CYC,
  parameter int USER_EDGES = scs_pkg::USR_INIT_EDGES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Configuration link
  scs_link_if.dev link,
  // Configuration options, static during a load
  input wire logic active_serial_mode,
  input wire logic as_x4,
  input wire logic [1:0] rate_sel,
  input wire logic chain_mode,
  input wire logic init_user_clk,
  input wire logic init_done_en,
  input wire logic dual_purpose_io,
  // User start-up clock pin
  input wire logic user_start_clk,
  // Received configuration words
  output logic m_valid,
  input wire logic m_ready,
  output logic [W-1:0] m_data,
  // Status
  output logic user_mode,
  output logic init_done_n,
  output logic init_done_oe,
  output logic user_io_in,
  output logic cfg_error
);
  scs_pkg::scs_dev_state_t state;
  scs_pkg::scs_dev_state_t next_state;

  logic [7:0] sync1;
  logic [7:0] sync2;
  logic ps_clk_d;
  logic usr_clk_d;
  logic [31:0] tmr;
  logic [15:0] ecnt;
  logic [15:0] bcnt;
  logic [7:0] wcnt;
  logic [W-1:0] sh;
  logic push_v;
  logic [W-1:0] push_d;
  logic [3:0] div_cnt;
  logic [7:0] cmd_sh;
  logic [3:0] cmd_cnt;
  logic init_en;
  logic f_ready;

  // Pin inputs pass two flops; only sync2 is read
  wire [7:0] pins = {user_start_clk, link.flash_data_lines,
                     link.serial_config_in, link.config_clock,
                     link.config_request_n};
  wire req_n = sync2[0];
  wire ps_clk = sync2[1];
  wire ps_dat = sync2[2];
  wire [3:0] fl = sync2[6:3];
  wire usr_clk = sync2[7];

  wire as = active_serial_mode;
  wire quad = as && as_x4;
  wire ps_rise = ps_clk && !ps_clk_d;
  wire ps_fall = !ps_clk && ps_clk_d;
  wire usr_rise = usr_clk && !usr_clk_d;
  wire in_load = state == scs_pkg::ST_LOAD;
  wire all_in = bcnt == 16'(CFG_BITS);

  // Chained loading never runs at the fastest rate
  wire [1:0] eff_rate = (chain_mode && rate_sel == scs_pkg::RATE_FAST) ?
                        scs_pkg::RATE_CHAIN : rate_sel;
  wire [3:0] half = (eff_rate == 2'h0) ? scs_pkg::HALF_R0 :
                    (eff_rate == 2'h1) ? scs_pkg::HALF_R1 :
                    (eff_rate == 2'h2) ? scs_pkg::HALF_R2 :
                    scs_pkg::HALF_R3;

  // The divider stalls while a word waits for FIFO space
  wire clk_run = as && ((in_load && !all_in && f_ready && !push_v) ||
                 state == scs_pkg::ST_DONE);
  wire tog = clk_run && (div_cnt == half - 4'h1);
  wire dev_fall = tog && link.dev_clk_o;
  wire cmd_sent = cmd_cnt == 4'(scs_pkg::CMD_BITS);

  // Bits beyond the image length are ignored
  wire smp = in_load && !all_in &&
             (as ? (dev_fall && cmd_sent) : ps_rise);
  wire [7:0] nbits = quad ? 8'h04 : 8'h01;
  wire bit_in = as ? fl[0] : ps_dat;
  wire [W-1:0] sh_next = quad ? {fl, sh[W-1:4]} :
                         {bit_in, sh[W-1:1]};
  wire word_full = smp && (wcnt + nbits == 8'(W));

  // Passive mode cannot stall the host, so a full FIFO is fatal
  wire ovf = push_v && !f_ready;
  wire fall_evt = as ? dev_fall : ps_fall;
  wire usr_ok = tmr >= 32'(scs_pkg::USR_DELAY_CYC);
  wire ecnt_evt = (state == scs_pkg::ST_DONE) ? fall_evt :
                  (state == scs_pkg::ST_INIT && init_user_clk &&
                   usr_ok) ? usr_rise : 1'b0;
  wire init_ok = init_user_clk ? (ecnt >= 16'(USER_EDGES)) :
                 (tmr >= 32'(INIT_CYC - 1));
  wire enter_load = next_state == scs_pkg::ST_LOAD && !in_load;
  wire next_cplt = next_state == scs_pkg::ST_DONE ||
                   next_state == scs_pkg::ST_INIT ||
                   next_state == scs_pkg::ST_USER;
  wire next_low = next_state == scs_pkg::ST_HOLD ||
                  next_state == scs_pkg::ST_ERR;

  always_comb begin
    next_state = state;
    case (state)
      // Reset lands here too, covering the power-on delay
      scs_pkg::ST_HOLD: begin
        if (req_n && tmr >= 32'(STATUS_LOW_CYC - 1)) begin
          next_state = scs_pkg::ST_LOAD;
        end
      end
      scs_pkg::ST_LOAD: begin
        if (ovf) begin
          next_state = scs_pkg::ST_ERR;
        end else if (all_in && !push_v) begin
          next_state = scs_pkg::ST_DONE;
        end
      end
      scs_pkg::ST_DONE: begin
        if (ecnt == 16'(scs_pkg::TAIL_FALLS)) begin
          next_state = scs_pkg::ST_INIT;
        end
      end
      scs_pkg::ST_INIT: begin
        if (init_ok) begin
          next_state = scs_pkg::ST_USER;
        end
      end
      scs_pkg::ST_USER: next_state = state;
      scs_pkg::ST_ERR: next_state = state;
      default: next_state = scs_pkg::ST_HOLD;
    endcase
    // A falling request restarts from any state other than ST_HOLD
    if (!req_n && state != scs_pkg::ST_HOLD) begin
      next_state = scs_pkg::ST_HOLD;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 8'h01;
      sync2 <= 8'h01;
      ps_clk_d <= 1'b0;
      usr_clk_d <= 1'b0;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      ps_clk_d <= ps_clk;
      usr_clk_d <= usr_clk;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= scs_pkg::ST_HOLD;
      tmr <= 32'h0;
      ecnt <= 16'h0;
    end else begin
      state <= next_state;
      tmr <= (next_state != state) ? 32'h0 : tmr + 32'h1;
      ecnt <= (next_state != state) ? 16'h0 : ecnt + 16'(ecnt_evt);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bcnt <= 16'h0;
      wcnt <= 8'h0;
      sh <= '0;
      push_v <= 1'b0;
      push_d <= '0;
    end else if (enter_load) begin
      bcnt <= 16'h0;
      wcnt <= 8'h0;
      push_v <= 1'b0;
    end else begin
      push_v <= word_full;
      if (word_full) begin
        push_d <= sh_next;
      end
      if (smp) begin
        sh <= sh_next;
        bcnt <= bcnt + 16'(nbits);
        wcnt <= word_full ? 8'h0 : wcnt + nbits;
      end
    end
  end

  // Device-made clock: command shifts out on each falling edge until its eight bits are sent
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 4'h0;
      link.dev_clk_o <= 1'b0;
      link.dev_clk_oe <= 1'b0;
      cmd_sh <= 8'h0;
      cmd_cnt <= 4'h0;
    end else begin
      div_cnt <= (tog || !clk_run) ? 4'h0 : div_cnt + 4'h1;
      link.dev_clk_o <= tog ? !link.dev_clk_o : link.dev_clk_o;
      link.dev_clk_oe <= as;
      if (enter_load) begin
        cmd_sh <= scs_pkg::READ_CMD;
        cmd_cnt <= 4'h0;
      end else if (dev_fall && in_load && !cmd_sent) begin
        cmd_sh <= {cmd_sh[6:0], 1'b0};
        cmd_cnt <= cmd_cnt + 4'h1;
      end
    end
  end

  assign link.flash_command_out = cmd_sh[7];

  // Link and user status registered from the next state, init_done_oe from init_en
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link.status_low_oe <= 1'b1;
      link.config_complete <= 1'b0;
      init_en <= 1'b0;
      init_done_oe <= 1'b0;
      init_done_n <= 1'b1;
      user_mode <= 1'b0;
      user_io_in <= 1'b0;
      cfg_error <= 1'b0;
    end else begin
      link.status_low_oe <= next_low;
      link.config_complete <= next_cplt;
      if (next_state == scs_pkg::ST_DONE) begin
        init_en <= init_done_en;
      end
      init_done_oe <= init_en;
      init_done_n <= !(init_en &&
                       next_state != scs_pkg::ST_USER);
      user_mode <= next_state == scs_pkg::ST_USER;
      user_io_in <= next_state == scs_pkg::ST_USER && dual_purpose_io &&
                    ps_dat;
      cfg_error <= next_state == scs_pkg::ST_ERR;
    end
  end

  scs_fifo #(
    .W(W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .s_valid(push_v),
    .s_ready(f_ready),
    .s_data(push_d),
    .m_valid(m_valid),
    .m_ready(m_ready),
    .m_data(m_data)
  );
endmodule

// ### scs_pkg.sv
// Shared constants and types for the serial configuration sequencer
package scs_pkg;
  localparam int CLK_NS = 10;
  localparam int REQ_LOW_US = 2;
  localparam int REQ_LOW_CYC = (REQ_LOW_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int STATUS_LOW_US = 268;
  localparam int STATUS_LOW_CYC =
    (STATUS_LOW_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int ST2CK_US = 2;
  localparam int ST2CK_CYC = (ST2CK_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int INIT_MIN_US = 175;
  localparam int INIT_CYC = (INIT_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int CFG_CLK_MAX_PERIOD_NS = 8;
  localparam int USR_DELAY_PERIODS = 4;
  localparam int USR_DELAY_CYC =
    (USR_DELAY_PERIODS * CFG_CLK_MAX_PERIOD_NS + CLK_NS - 1) / CLK_NS;
  localparam int USR_INIT_EDGES = 8576;
  localparam int TAIL_FALLS = 2;
  localparam int CMD_BITS = 8;
  localparam logic [7:0] READ_CMD = 8'h03;
  localparam logic [1:0] RATE_FAST = 2'h3;
  localparam logic [1:0] RATE_CHAIN = 2'h2;
  localparam logic [3:0] HALF_R0 = 4'h8;
  localparam logic [3:0] HALF_R1 = 4'h4;
  localparam logic [3:0] HALF_R2 = 4'h2;
  localparam logic [3:0] HALF_R3 = 4'h1;
  localparam logic [3:0] HOST_HALF = 4'h4;

  typedef enum logic [2:0] {
    ST_HOLD = 3'b000,
    ST_LOAD = 3'b001,
    ST_DONE = 3'b010,
    ST_INIT = 3'b011,
    ST_USER = 3'b100,
    ST_ERR  = 3'b101
  } scs_dev_state_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_REQ  = 3'b001,
    H_WAIT = 3'b010,
    H_GAP  = 3'b011,
    H_SEND = 3'b100,
    H_TAIL = 3'b101,
    H_PARK = 3'b110
  } scs_host_state_t;
endpackage

// ### scs_link_if.sv
// Configuration link between the loading device and its data source
`timescale 1ns/1ps
interface scs_link_if;
  logic config_request_n;
  logic status_low_oe;
  logic config_status_n;
  logic config_complete;
  logic dev_clk_o;
  logic dev_clk_oe;
  logic host_clk_o;
  logic host_clk_oe;
  logic config_clock;
  logic serial_config_in;
  logic [3:0] flash_data_lines;
  logic flash_command_out;

  // Status is open drain with a pull-up; an undriven clock reads low
  assign config_status_n = ~status_low_oe;
  assign config_clock = dev_clk_oe ? dev_clk_o :
                        (host_clk_oe ? host_clk_o : 1'b0);

  modport dev (
    input config_request_n,
    input config_clock,
    input serial_config_in,
    input flash_data_lines,
    output status_low_oe,
    output config_complete,
    output dev_clk_o,
    output dev_clk_oe,
    output flash_command_out
  );

  modport host (
    input config_status_n,
    input config_complete,
    input config_clock,
    input flash_command_out,
    output config_request_n,
    output host_clk_o,
    output host_clk_oe,
    output serial_config_in,
    output flash_data_lines
  );
endinterface

// ### scs_fifo.sv
// Word FIFO between the bit assembler and the user stream
`timescale 1ns/1ps
module scs_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic s_valid,
  output logic s_ready,
  input wire logic [W-1:0] s_data,
  // Drain side
  output logic m_valid,
  input wire logic m_ready,
  output logic [W-1:0] m_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;

  wire push = s_valid && s_ready;
  wire pop = m_valid && m_ready;

  assign s_ready = count != (AW+1)'(DEPTH);
  assign m_valid = count != '0;
  assign m_data = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= s_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= push ? wr_ptr + AW'(1) : wr_ptr;
      rd_ptr <= pop ? rd_ptr + AW'(1) : rd_ptr;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ### scs_host.sv
// Data source end: passive-mode host or active-mode flash stand-in
`timescale 1ns/1ps
module scs_host #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Configuration link
  scs_link_if.host link,
  // Control
  input wire logic start,
  input wire logic as_mode,
  input wire logic as_x4,
  // Configuration words, first bit in bit 0
  input wire logic s_valid,
  output logic s_ready,
  input wire logic [W-1:0] s_data,
  // Status
  output logic busy,
  output logic cfg_done
);
  scs_pkg::scs_host_state_t state;
  scs_pkg::scs_host_state_t next_state;

  logic [3:0] sync1;
  logic [3:0] sync2;
  logic clk_d;
  logic [31:0] tmr;
  logic [3:0] div_cnt;
  logic [W-1:0] sh;
  logic [7:0] cnt;
  logic [7:0] op;
  logic [3:0] opc;
  logic [1:0] falls;

  wire st_n = sync2[0];
  wire cplt = sync2[1];
  wire cclk = sync2[2];
  wire cmd = sync2[3];
  wire c_rise = cclk && !clk_d;
  wire c_fall = !cclk && clk_d;
  wire sending = state == scs_pkg::H_SEND;
  wire take = s_valid && s_ready;
  wire [7:0] k = (as_mode && as_x4) ? 8'h04 : 8'h01;
  wire armed = opc == 4'(scs_pkg::CMD_BITS) && op == scs_pkg::READ_CMD;
  wire ps_run = !as_mode && ((sending && cnt != 8'h0) ||
                state == scs_pkg::H_TAIL);
  wire tog = ps_run && div_cnt == scs_pkg::HOST_HALF - 4'h1;
  wire h_fall = tog && link.host_clk_o;
  wire shift = sending && cnt != 8'h0 &&
               (as_mode ? (c_fall && armed) : h_fall);
  wire [7:0] next_cnt = take ? 8'(W) : (shift ? cnt - k : cnt);

  always_comb begin
    next_state = state;
    case (state)
      scs_pkg::H_IDLE: if (start) next_state = scs_pkg::H_REQ;
      scs_pkg::H_REQ: begin
        if (tmr >= 32'(scs_pkg::REQ_LOW_CYC - 1)) begin
          next_state = scs_pkg::H_WAIT;
        end
      end
      // Flash role answers at once: the device clocks as status rises
      scs_pkg::H_WAIT: begin
        if (st_n) begin
          next_state = as_mode ? scs_pkg::H_SEND : scs_pkg::H_GAP;
        end
      end
      scs_pkg::H_GAP: begin
        if (tmr >= 32'(scs_pkg::ST2CK_CYC - 1)) begin
          next_state = scs_pkg::H_SEND;
        end
      end
      scs_pkg::H_SEND: begin
        if (cplt) begin
          next_state = as_mode ? scs_pkg::H_PARK : scs_pkg::H_TAIL;
        end
      end
      scs_pkg::H_TAIL: begin
        if (falls == 2'(scs_pkg::TAIL_FALLS)) begin
          next_state = scs_pkg::H_PARK;
        end
      end
      scs_pkg::H_PARK: if (start) next_state = scs_pkg::H_REQ;
      default: next_state = scs_pkg::H_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      clk_d <= 1'b0;
      state <= scs_pkg::H_IDLE;
      tmr <= 32'h0;
      falls <= 2'h0;
    end else begin
      sync1 <= {link.flash_command_out, link.config_clock,
                link.config_complete, link.config_status_n};
      sync2 <= sync1;
      clk_d <= cclk;
      state <= next_state;
      tmr <= (next_state != state) ? 32'h0 : tmr + 32'h1;
      falls <= (next_state != state) ? 2'h0 : falls + 2'(h_fall);
    end
  end

  // Passive clock: rises with data stable, data moves on the fall
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 4'h0;
      link.host_clk_o <= 1'b0;
      link.host_clk_oe <= 1'b0;
      link.config_request_n <= 1'b1;
    end else begin
      div_cnt <= (tog || !ps_run) ? 4'h0 : div_cnt + 4'h1;
      link.host_clk_o <= tog ? !link.host_clk_o : link.host_clk_o;
      link.host_clk_oe <= !as_mode;
      link.config_request_n <= next_state != scs_pkg::H_REQ;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh <= '0;
      cnt <= 8'h0;
      op <= 8'h0;
      opc <= 4'h0;
      s_ready <= 1'b0;
      link.serial_config_in <= 1'b0;
      link.flash_data_lines <= 4'h0;
      busy <= 1'b0;
      cfg_done <= 1'b0;
    end else begin
      cnt <= sending ? next_cnt : 8'h0;
      s_ready <= next_state == scs_pkg::H_SEND && next_cnt == 8'h0;
      if (take) begin
        sh <= s_data;
      end else if (shift) begin
        sh <= sh >> k;
      end
      link.serial_config_in <= take ? s_data[0] :
                               (shift ? sh[1] : link.serial_config_in);
      if (shift && as_mode) begin
        link.flash_data_lines <= as_x4 ? sh[3:0] :
                                 {3'b000, sh[0]};
      end
      if (!sending) begin
        opc <= 4'h0;
      end else if (c_rise && opc != 4'(scs_pkg::CMD_BITS)) begin
        op <= {op[6:0], cmd};
        opc <= opc + 4'h1;
      end
      busy <= next_state != scs_pkg::H_IDLE &&
              next_state != scs_pkg::H_PARK;
      cfg_done <= next_state == scs_pkg::H_PARK;
    end
  end
endmodule

// ### scs_link_properties.sv
// Timing properties watched on the link between host and device
`timescale 1ns/1ps
module scs_link_properties #(
  parameter int CFG_BITS = 64,
  parameter int STATUS_LOW_CYC = 50
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link signals
  input wire logic config_request_n,
  input wire logic config_status_n,
  input wire logic config_complete,
  input wire logic config_clock,
  input wire logic dev_clk_o,
  input wire logic dev_clk_oe,
  input wire logic host_clk_oe,
  input wire logic flash_command_out
);
  localparam int REL_MAX = STATUS_LOW_CYC + 8;
  int low_cnt;
  int hi_cnt;
  int rises;
  int req_cnt;
  logic clk_q;
  wire clk_rise = config_clock && !clk_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Run lengths of status, and clock rises since status went high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt <= 0;
      hi_cnt <= 0;
      rises <= 0;
      req_cnt <= 0;
      clk_q <= 1'b0;
    end else begin
      low_cnt <= config_status_n ? 0 : low_cnt + 1;
      hi_cnt <= config_status_n ? hi_cnt + 1 : 0;
      rises <= config_status_n ? rises + int'(clk_rise) : 0;
      req_cnt <= config_request_n ? 0 : req_cnt + 1;
      clk_q <= config_clock;
    end
  end

  request_width_a:
    assert property ($rose(config_request_n) |->
      req_cnt >= scs_pkg::REQ_LOW_CYC)
    else $error("request low pulse too short");

  status_answer_a:
    assert property ($fell(config_request_n) |-> ##[1:4]
      (!config_status_n && !config_complete))
    else $error("status or done late after request");
  status_pulse_a:
    assert property ($rose(config_status_n) |-> low_cnt >= STATUS_LOW_CYC)
    else $error("status low pulse too short");
  status_release_a:
    assert property ($rose(config_request_n) |-> ##[1:REL_MAX]
      config_status_n)
    else $error("status not released after request");
  status_needs_req_a:
    assert property ($rose(config_status_n) |->
      config_request_n && $past(config_request_n, 3))
    else $error("status rose while request low");
  done_after_data_a:
    assert property ($rose(config_complete) |->
      config_status_n && rises >= CFG_BITS / 4)
    else $error("done rose before the data");
  done_holds_a:
    assert property ($fell(config_complete) |-> !config_request_n)
    else $error("done fell without a request");
  launch_on_fall_a:
    assert property (dev_clk_oe && $changed(flash_command_out) |->
      !dev_clk_o)
    else $error("command bit changed with clock high");
  clock_owner_a:
    assert property (dev_clk_oe && config_status_n && !config_complete
      |-> !host_clk_oe)
    else $error("both ends drive the clock");
  first_clock_gap_a:
    assert property (clk_rise && !dev_clk_oe && config_status_n |->
      hi_cnt >= scs_pkg::ST2CK_CYC)
    else $error("clock rose too soon after status");
endmodule

// ### serial_config_sequencer_bench.sv
// Self-checking bench: host and device joined across the link
`timescale 1ns/1ps
module serial_config_sequencer_bench;
  localparam int NW = 20;
  localparam int CFG_BITS = NW * 8;
  localparam int INIT_CYC = 40;
  localparam int USER_EDGES = 16;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic as_mode = 1'b0;
  logic as_x4 = 1'b0;
  logic init_user_clk = 1'b0;
  logic [1:0] rate_sel = 2'h0;
  logic dpio = 1'b0;
  logic user_start_clk = 1'b0;
  logic drain = 1'b1;
  logic m_ready = 1'b0;
  logic s_valid = 1'b0;
  logic [7:0] s_data = 8'h00;
  logic [7:0] m_data;
  logic m_valid, s_ready, busy, cfg_done, user_mode;
  logic init_done_n, init_done_oe, user_io_in, cfg_error;
  int sidx = 0;
  int ridx = 0;
  int icnt = 0;
  int errors = 0;
  int compares = 0;

  scs_link_if u_scs_link_if ();
  scs_device #(.CFG_BITS(CFG_BITS), .STATUS_LOW_CYC(50),
    .INIT_CYC(INIT_CYC), .USER_EDGES(USER_EDGES)) u_scs_device (
    .clk(clk), .rst_n(rst_n), .link(u_scs_link_if),
    .active_serial_mode(as_mode), .as_x4(as_x4), .rate_sel(rate_sel),
    .chain_mode(1'b0), .init_user_clk(init_user_clk),
    .init_done_en(1'b1), .dual_purpose_io(dpio),
    .user_start_clk(user_start_clk), .m_valid(m_valid),
    .m_ready(m_ready), .m_data(m_data), .user_mode(user_mode),
    .init_done_n(init_done_n), .init_done_oe(init_done_oe),
    .user_io_in(user_io_in), .cfg_error(cfg_error));
  scs_host u_scs_host (
    .clk(clk), .rst_n(rst_n), .link(u_scs_link_if), .start(start),
    .as_mode(as_mode), .as_x4(as_x4), .s_valid(s_valid),
    .s_ready(s_ready), .s_data(s_data), .busy(busy),
    .cfg_done(cfg_done));
  scs_link_properties #(.CFG_BITS(CFG_BITS), .STATUS_LOW_CYC(50))
    u_scs_link_properties (
    .clk(clk), .rst_n(rst_n),
    .config_request_n(u_scs_link_if.config_request_n),
    .config_status_n(u_scs_link_if.config_status_n),
    .config_complete(u_scs_link_if.config_complete),
    .config_clock(u_scs_link_if.config_clock),
    .dev_clk_o(u_scs_link_if.dev_clk_o),
    .dev_clk_oe(u_scs_link_if.dev_clk_oe),
    .host_clk_oe(u_scs_link_if.host_clk_oe),
    .flash_command_out(u_scs_link_if.flash_command_out));

  initial begin
    forever #5 clk = ~clk;
  end
  // Start-up clock toggles every 40 ns, on falling edges of clk
  initial begin
    forever #40 user_start_clk = ~user_start_clk;
  end

  function automatic logic [7:0] word(input int i);
    return 8'(i * 37) ^ 8'h5A;
  endfunction

  task automatic stop_test();
    if (errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_bit(input string what, input logic exp,
    input logic got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_range(input string what, input int lo,
    input int hi, input int got);
    compares++;
    if (got < lo || got > hi) begin
      errors++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  function automatic logic flag(input int k);
    case (k)
      0: return u_scs_link_if.config_complete;
      1: return user_mode;
      2: return cfg_done;
      default: return cfg_error;
    endcase
  endfunction

  task automatic wait_for(input int k, input int lim);
    int n;
    n = 0;
    while (flag(k) !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > lim) begin
        errors++;
        $display("mismatch wait %0d expected 1 seen timeout", k);
        stop_test();
      end
    end
  endtask

  // Word source for the host
  always @(posedge clk) begin
    if (s_valid && s_ready) begin
      sidx <= sidx + 1;
      s_valid <= sidx + 1 < NW;
      s_data <= word(sidx + 1);
    end
  end

  // Consumer stalls every other cycle so the FIFO holds words meanwhile
  always @(posedge clk) begin
    if (m_valid && m_ready) begin
      check("word", word(ridx), m_data);
      ridx <= ridx + 1;
    end
    m_ready <= drain & ~m_ready;
    icnt <= (!u_scs_link_if.config_complete || user_mode) ? 0 : icnt + 1;
  end

  task automatic run(input logic act, input logic x4, input logic usr,
    input logic ok);
    @(posedge clk);
    as_mode <= act;
    as_x4 <= x4;
    init_user_clk <= usr;
    // Single-bit active loads run at the slowest rate, quad at the next
    rate_sel <= x4 ? 2'h1 : 2'h0;
    dpio <= x4 || !act;
    drain <= ok;
    sidx <= 0;
    ridx <= 0;
    s_data <= word(0);
    s_valid <= 1'b1;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (20) @(posedge clk);
    #1;
    check_bit("status", 1'b0, u_scs_link_if.config_status_n);
    check_bit("done", 1'b0, u_scs_link_if.config_complete);
    check_bit("busy", 1'b1, busy);
    check_bit("request", 1'b0, u_scs_link_if.config_request_n);
    if (!ok) begin
      // Consumer never drains, so the seventeenth word overflows
      wait_for(3, 5000);
      check_bit("status", 1'b0, u_scs_link_if.config_status_n);
      check_bit("done", 1'b0, u_scs_link_if.config_complete);
      return;
    end
    wait_for(0, 5000);
    repeat (3) @(posedge clk);
    #1;
    check_bit("init", 1'b0, init_done_n);
    check_bit("user", 1'b0, user_mode);
    wait_for(1, 1000);
    check_range("init", usr ? 4 + (USER_EDGES - 1) * 8 : INIT_CYC,
      usr ? USER_EDGES * 8 + 60 : INIT_CYC * 437 / 175, icnt);
    check_range("words", NW, NW, ridx);
    check_bit("init oe", 1'b1, init_done_oe);
    check_bit("init", 1'b1, init_done_n);
    check_bit("user io", dpio & u_scs_link_if.serial_config_in,
      user_io_in);
    wait_for(2, 1000);
    check_bit("busy", 1'b0, busy);
    check_bit("status", 1'b1, u_scs_link_if.config_status_n);
    check_bit("done", 1'b1, u_scs_link_if.config_complete);
    if (!act) begin
      check_bit("clk oe", 1'b1, u_scs_link_if.host_clk_oe);
      check_bit("clk", 1'b0, u_scs_link_if.config_clock);
    end
  endtask

  initial begin
    repeat (12) @(posedge clk);
    #2 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check_bit("status", 1'b0, u_scs_link_if.config_status_n);
    check_bit("done", 1'b0, u_scs_link_if.config_complete);
    run(1'b0, 1'b0, 1'b0, 1'b1);
    run(1'b1, 1'b1, 1'b1, 1'b1);
    run(1'b1, 1'b0, 1'b0, 1'b1);
    run(1'b0, 1'b0, 1'b0, 1'b0);
    stop_test();
  end
endmodule
